// >>> design/_unused_placeholder_removed.sv
// intentionally empty: no further logic
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> design/mcr_card_regs.sv
// What this block does
// - 32-bit voltage profile register, read only
// - 16-byte identity fixed, host writes ignored
// - identity fields packed, checksum, bit0 one
// - card data fields read-only, once, or rewritable
// - 128-bit card specific data register held
// - card proposes relative address, host approves
// - optional 16-bit driver stage register
// - 64-bit feature configuration register, read only
// - lines one to three inputs until width
// - detect pull-up on at power-up, command clears
// - detect pin level seen while pull-up on
// - serial select, input and output roles
// - power-on reset places card idle
// - reset command returns card to idle
// - only line zero carries data initially
//
// card register set with wishbone access and a serial command link
// assumes link pins come from the host, asynchronous to clock
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module mcr_card_regs #(
    parameter logic [31:0]  VOLT_PROFILE  = 32'h00FF_8000,
    // identity field values below are arbitrary
    parameter logic [7:0]   MAKER_CODE    = 8'h5A,
    parameter logic [15:0]  APP_CODE      = 16'h4142,
    parameter logic [39:0]  PRODUCT_NAME  = 40'h4341_5244_30,
    parameter logic [7:0]   PRODUCT_REV   = 8'h10,
    parameter logic [31:0]  SERIAL_NUMBER = 32'h1234_5678,
    parameter logic [11:0]  MFG_DATE      = 12'h0A1,
    parameter logic [127:0] CSD_DEFAULT   = 128'h0026_0032_5F59_83C8_BEFB_CFFF_9240_4001,
    parameter logic [127:0] CSD_RW_MASK   = 128'h0000_0000_0000_0000_0000_0000_0000_3000,
    parameter logic [127:0] CSD_OTP_MASK  = 128'h0000_0000_0000_0000_0000_0000_0000_C000,
    parameter logic [63:0]  FEATURE_CFG   = 64'h0225_0000_0000_0000,
    parameter logic [15:0]  DSR_DEFAULT   = 16'h0404,
    parameter logic [15:0]  RCA_SEED      = 16'h0001
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        link_clk,
    input  wire logic        detect_or_line3,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_oe,
    output logic             pullup_en,
    output logic [3:0]       data_line_en,
    output logic [15:0]      driver_stage
);
    mcr_link_if lk ();

    mcr_link u_link (
        .clock         (clock),
        .reset_n       (reset_n),
        .link_clk      (link_clk),
        .select_n      (detect_or_line3),
        .serial_in     (serial_in),
        .serial_out    (serial_out),
        .serial_out_oe (serial_out_oe),
        .lk            (lk)
    );

    function automatic logic [6:0] crc7(input logic [119:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 119; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
        end
        return r;
    endfunction

    localparam logic [119:0] CID_BODY = {MAKER_CODE, APP_CODE, PRODUCT_NAME, PRODUCT_REV,
                                         SERIAL_NUMBER, 4'h0, MFG_DATE};
    // identity is wired from parameters, so no write path exists at all
    localparam logic [127:0] CARD_ID = {CID_BODY, crc7(CID_BODY), 1'b1};

    logic [127:0] csd_q;
    logic         otp_lock_q;
    logic [15:0]  rca_q;
    logic [15:0]  rca_seed_q;
    logic         rca_valid_q;
    logic [15:0]  dsr_q;
    logic         idle_q;
    logic         spi_q;
    logic         pullup_q;
    logic         wide_q;
    logic         app_q;
    logic [5:0]   last_cmd_q;
    logic         wb_ack_q;
    logic [31:0]  wb_dat_q;
    logic [31:0]  rd_word;
    logic         wb_take;
    logic         wb_wr;
    logic [31:0]  status;
    logic [5:0]   wsel;
    logic [127:0] csd_wmask;
    logic [7:0]   r1;

    assign wb_take  = wb_cyc_i && wb_stb_i && !wb_ack_q;
    assign wb_wr    = wb_take && wb_we_i;
    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;
    // addresses below the block wrap high, so only its four words fall under 4
    assign wsel     = wb_adr_i[7:2] - mcr_pkg::OFF_CSD0[7:2];

    always_comb begin
        status = 32'h0000_0000;
        status[mcr_pkg::ST_IDLE]   = idle_q;
        status[mcr_pkg::ST_SPI]    = spi_q;
        status[mcr_pkg::ST_PULLUP] = pullup_q;
        status[mcr_pkg::ST_WIDE]   = wide_q;
        status[mcr_pkg::ST_RCAOK]  = rca_valid_q;
        // the pin only means insertion while the pull-up holds it high
        status[mcr_pkg::ST_DETECT] = pullup_q & lk.select_level;
        status[mcr_pkg::ST_OTPLCK] = otp_lock_q;
        status[mcr_pkg::ST_CMD +: 6] = last_cmd_q;
    end

    // word order on the bus: lowest offset holds the top word
    always_comb begin
        rd_word = 32'h0000_0000;
        case (wb_adr_i[7:2])
            mcr_pkg::OFF_VOLT[7:2]:        rd_word = VOLT_PROFILE;
            mcr_pkg::OFF_CID0[7:2]:        rd_word = CARD_ID[127:96];
            mcr_pkg::OFF_CID0[7:2] + 6'h1: rd_word = CARD_ID[95:64];
            mcr_pkg::OFF_CID0[7:2] + 6'h2: rd_word = CARD_ID[63:32];
            mcr_pkg::OFF_CID0[7:2] + 6'h3: rd_word = CARD_ID[31:0];
            mcr_pkg::OFF_CSD0[7:2]:        rd_word = csd_q[127:96];
            mcr_pkg::OFF_CSD0[7:2] + 6'h1: rd_word = csd_q[95:64];
            mcr_pkg::OFF_CSD0[7:2] + 6'h2: rd_word = csd_q[63:32];
            mcr_pkg::OFF_CSD0[7:2] + 6'h3: rd_word = csd_q[31:0];
            mcr_pkg::OFF_RCA[7:2]:         rd_word = {16'h0000, rca_q};
            mcr_pkg::OFF_DSR[7:2]:         rd_word = {16'h0000, dsr_q};
            mcr_pkg::OFF_SCR0[7:2]:        rd_word = FEATURE_CFG[63:32];
            mcr_pkg::OFF_SCR0[7:2] + 6'h1: rd_word = FEATURE_CFG[31:0];
            mcr_pkg::OFF_STATUS[7:2]:      rd_word = status;
            mcr_pkg::OFF_CONTROL[7:2]:     rd_word = {16'h0000, rca_seed_q};
            default:                       rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h0000_0000;
        end else begin
            wb_ack_q <= wb_take;
            if (wb_take && !wb_we_i) begin
                wb_dat_q <= rd_word;
            end
        end
    end

    // otp cells take only the first write to any card data word, then only rewritable cells move
    assign csd_wmask = CSD_RW_MASK | (otp_lock_q ? 128'h0 : CSD_OTP_MASK);

    genvar gw;
    generate
        for (gw = 0; gw < 4; gw++) begin : g_csd
            localparam int LO = 96 - gw * 32;
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    csd_q[LO +: 32] <= CSD_DEFAULT[LO +: 32];
                end else if (wb_wr && wsel == 6'(gw)) begin
                    csd_q[LO +: 32] <= (csd_q[LO +: 32] & ~csd_wmask[LO +: 32]) |
                        (merge(csd_q[LO +: 32], wb_dat_i, wb_sel_i) & csd_wmask[LO +: 32]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            otp_lock_q <= 1'b0;
        end else if (wb_wr && wsel < 6'h04) begin
            otp_lock_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dsr_q <= DSR_DEFAULT;
        end else if (lk.cmd_valid && lk.cmd_idx == mcr_pkg::CMD_SET_DSR && !app_q) begin
            dsr_q <= lk.cmd_arg[31:16];
        end else if (wb_wr && wb_adr_i[7:2] == mcr_pkg::OFF_DSR[7:2]) begin
            dsr_q <= 16'(merge({16'h0000, dsr_q}, wb_dat_i, wb_sel_i));
        end
    end

    // kept apart so a command in the same cycle cannot swallow an acked write
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rca_seed_q <= RCA_SEED;
        end else if (wb_wr && wb_adr_i[7:2] == mcr_pkg::OFF_CONTROL[7:2]) begin
            rca_seed_q <= 16'(merge({16'h0000, rca_seed_q}, wb_dat_i, wb_sel_i));
        end
    end
    assign driver_stage = dsr_q;

    // command state; the reset command clears it like power-on reset but sets spi_q from the pull-up and keeps rca_q
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            idle_q      <= 1'b1;
            spi_q       <= 1'b0;
            pullup_q    <= 1'b1;
            wide_q      <= 1'b0;
            app_q       <= 1'b0;
            rca_q       <= 16'h0000;
            rca_valid_q <= 1'b0;
            last_cmd_q  <= 6'h00;
        end else if (lk.cmd_valid) begin
            last_cmd_q <= lk.cmd_idx;
            app_q      <= (lk.cmd_idx == mcr_pkg::CMD_APP);
            if (lk.cmd_idx == mcr_pkg::CMD_GO_IDLE) begin
                idle_q      <= 1'b1;
                spi_q       <= pullup_q && !lk.select_level;
                pullup_q    <= 1'b1;
                wide_q      <= 1'b0;
                rca_valid_q <= 1'b0;
            end else if (!app_q && lk.cmd_idx == mcr_pkg::CMD_OP_COND ||
                         app_q && lk.cmd_idx == mcr_pkg::ACMD_OPCOND) begin
                idle_q <= 1'b0;
            end else if (!app_q && lk.cmd_idx == mcr_pkg::CMD_SEND_RCA) begin
                // the host approves by addressing the card with this value
                rca_q       <= rca_seed_q;
                rca_valid_q <= 1'b1;
            end else if (app_q && lk.cmd_idx == mcr_pkg::ACMD_WIDTH) begin
                wide_q <= (lk.cmd_arg[1:0] == mcr_pkg::WIDTH_FOUR);
            end else if (app_q && lk.cmd_idx == mcr_pkg::ACMD_PULLUP) begin
                pullup_q <= lk.cmd_arg[0];
            end
        end
    end
    assign pullup_en    = pullup_q;
    assign data_line_en = wide_q ? 4'hF : 4'h1;

    always_comb begin
        r1 = 8'h00;
        r1[mcr_pkg::R1_IDLE] = idle_q;
        lk.resp_data = {r1, 128'h0};
        lk.resp_len  = mcr_pkg::LEN_R1;
        case ({app_q, lk.cmd_idx})
            {1'b0, mcr_pkg::CMD_READ_VP}: begin
                lk.resp_data = {r1, VOLT_PROFILE, 96'h0};
                lk.resp_len  = mcr_pkg::LEN_VOLT;
            end
            {1'b0, mcr_pkg::CMD_SEND_CID}: begin
                lk.resp_data = {r1, CARD_ID};
                lk.resp_len  = mcr_pkg::LEN_WIDE;
            end
            {1'b0, mcr_pkg::CMD_SEND_CSD}: begin
                lk.resp_data = {r1, csd_q};
                lk.resp_len  = mcr_pkg::LEN_WIDE;
            end
            {1'b0, mcr_pkg::CMD_SEND_RCA}: begin
                lk.resp_data = {r1, rca_seed_q, 112'h0};
                lk.resp_len  = mcr_pkg::LEN_RCA;
            end
            {1'b1, mcr_pkg::ACMD_SCR}: begin
                lk.resp_data = {r1, FEATURE_CFG, 64'h0};
                lk.resp_len  = mcr_pkg::LEN_SCR;
            end
            {1'b0, mcr_pkg::CMD_GO_IDLE}, {1'b0, mcr_pkg::CMD_OP_COND},
            {1'b0, mcr_pkg::CMD_SET_DSR}, {1'b0, mcr_pkg::CMD_APP},
            {1'b1, mcr_pkg::ACMD_OPCOND}, {1'b1, mcr_pkg::ACMD_WIDTH},
            {1'b1, mcr_pkg::ACMD_PULLUP}: begin
                lk.resp_data = {r1, 128'h0};
            end
            default: begin
                lk.resp_data = {r1 | 8'h04, 128'h0};
            end
        endcase
    end
    // answer built from state before the command acts; the copy only feeds a check
    logic resp_load_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            resp_load_q <= 1'b0;
        end else begin
            resp_load_q <= lk.cmd_valid;
        end
    end
    assign lk.resp_load = lk.cmd_valid;

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // full-word bus write with no command competing for the same register
    sequence s_bus_write(logic [7:0] a);
        wb_wr && wb_adr_i == a && wb_sel_i == 4'hF && !lk.cmd_valid;
    endsequence
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    a_reset_cmd_idle: assert property (lk.cmd_valid && lk.cmd_idx == mcr_pkg::CMD_GO_IDLE
        |=> idle_q && pullup_en && data_line_en == 4'h1)
        else $error("reset command did not return to idle");
    a_pullup_clear: assert property (lk.cmd_valid && app_q &&
        lk.cmd_idx == mcr_pkg::ACMD_PULLUP && !lk.cmd_arg[0] |=> !pullup_en)
        else $error("pull-up still connected after clear command");
    a_narrow_lines: assert property (!wide_q |-> data_line_en == 4'h1)
        else $error("extra data lines enabled before width change");
    a_dsr_write: assert property (s_bus_write(mcr_pkg::OFF_DSR)
        |=> driver_stage == $past(wb_dat_i[15:0]))
        else $error("driver stage write lost");
    a_cid_bit0: assert property (wb_take && !wb_we_i &&
        wb_adr_i == mcr_pkg::OFF_CID0 + 8'h0C |=> wb_ack_o && wb_dat_o[0])
        else $error("identity last bit not one");
    a_volt_read: assert property (wb_take && !wb_we_i && wb_adr_i == mcr_pkg::OFF_VOLT
        |=> wb_dat_o == VOLT_PROFILE)
        else $error("voltage profile read wrong");
    a_rca_propose: assert property (lk.cmd_valid && !app_q &&
        lk.cmd_idx == mcr_pkg::CMD_SEND_RCA |=> rca_q == $past(rca_seed_q) && rca_valid_q)
        else $error("relative address not proposed");
    a_otp_sticky: assert property (otp_lock_q |=> otp_lock_q)
        else $error("one-time cells unlocked again");
    a_answer_follows: assert property (lk.cmd_valid |-> lk.resp_load ##1 resp_load_q)
        else $error("command left without answer");
endmodule
`default_nettype wire

// >>> design/mcr_link.sv
// serial command link: samples host clock, select and data in
// assumes link pins are asynchronous to clock and much slower than it
`timescale 1ns/10ps
`default_nettype none
module mcr_link (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic link_clk,
    input  wire logic select_n,
    input  wire logic serial_in,
    output logic      serial_out,
    output logic      serial_out_oe,
    mcr_link_if.link  lk
);
    logic [2:0]                 clk_s_q;
    logic [1:0]                 sel_s_q;
    logic [1:0]                 din_s_q;
    logic [mcr_pkg::CMD_BITS-1:0] rx_q;
    logic [5:0]                 rx_cnt_q;
    logic [mcr_pkg::RESP_W-1:0] tx_q;
    logic [7:0]                 tx_cnt_q;
    logic                       rise;
    logic                       fall;
    logic                       selected;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clk_s_q <= 3'h0;
            sel_s_q <= 2'h3;
            din_s_q <= 2'h3;
        end else begin
            clk_s_q <= {clk_s_q[1:0], link_clk};
            sel_s_q <= {sel_s_q[0], select_n};
            din_s_q <= {din_s_q[0], serial_in};
        end
    end
    assign rise     = clk_s_q[1] & ~clk_s_q[2];
    assign fall     = ~clk_s_q[1] & clk_s_q[2];
    assign selected = ~sel_s_q[1];
    assign lk.select_level = sel_s_q[1];

    // a frame starts at the first zero bit; idle line is high
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_q         <= '0;
            rx_cnt_q     <= 6'h00;
            lk.cmd_valid <= 1'b0;
            lk.cmd_idx   <= 6'h00;
            lk.cmd_arg   <= 32'h0000_0000;
        end else begin
            lk.cmd_valid <= 1'b0;
            if (!selected) begin
                rx_cnt_q <= 6'h00;
            end else if (rise && (rx_cnt_q != 6'h00 || !din_s_q[1])) begin
                rx_q <= {rx_q[mcr_pkg::CMD_BITS-2:0], din_s_q[1]};
                if (rx_cnt_q == 6'(mcr_pkg::CMD_BITS - 1)) begin
                    rx_cnt_q     <= 6'h00;
                    lk.cmd_valid <= 1'b1;
                    lk.cmd_idx   <= rx_q[44:39];
                    lk.cmd_arg   <= rx_q[38:7];
                end else begin
                    rx_cnt_q <= rx_cnt_q + 6'h01;
                end
            end
        end
    end

    // answers leave on falling host clock edges, top bit first
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_q       <= '0;
            tx_cnt_q   <= 8'h00;
            serial_out <= 1'b1;
        end else if (!selected) begin
            tx_cnt_q   <= 8'h00;
            serial_out <= 1'b1;
        end else if (lk.resp_load) begin
            tx_q     <= lk.resp_data;
            tx_cnt_q <= lk.resp_len;
        end else if (fall) begin
            if (tx_cnt_q != 8'h00) begin
                serial_out <= tx_q[mcr_pkg::RESP_W-1];
                tx_q       <= {tx_q[mcr_pkg::RESP_W-2:0], 1'b1};
                tx_cnt_q   <= tx_cnt_q - 8'h01;
            end else begin
                serial_out <= 1'b1;
            end
        end
    end
    assign serial_out_oe = selected;

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_tx_msb_first: assert property (fall && selected && !lk.resp_load && tx_cnt_q != 8'h00
        |=> serial_out == $past(tx_q[mcr_pkg::RESP_W-1]))
        else $error("answer bit not taken from top of shifter");
    a_deselect_idle: assert property (!selected |=> serial_out && rx_cnt_q == 6'h00)
        else $error("link active while deselected");
endmodule
`default_nettype wire

// >>> design/mcr_link_if.sv
// carrier between the command link engine and the register core
// both ends run on the system clock
`timescale 1ns/10ps
`default_nettype none
interface mcr_link_if;
    logic                        cmd_valid;
    logic [5:0]                  cmd_idx;
    logic [31:0]                 cmd_arg;
    logic                        resp_load;
    logic [mcr_pkg::RESP_W-1:0]  resp_data;
    logic [7:0]                  resp_len;
    logic                        select_level;
    modport link (output cmd_valid, cmd_idx, cmd_arg, select_level,
                  input resp_load, resp_data, resp_len);
    modport core (input cmd_valid, cmd_idx, cmd_arg, select_level,
                  output resp_load, resp_data, resp_len);
endinterface
`default_nettype wire

// >>> design/mcr_pkg.sv
// constants of the card register set: bus map, commands, frame sizes
// assumes a 32-bit classic wishbone slave and a serial command link
package mcr_pkg;
    // wishbone word offsets (byte addresses)
    localparam logic [7:0] OFF_VOLT    = 8'h00;
    localparam logic [7:0] OFF_CID0    = 8'h04;
    localparam logic [7:0] OFF_CSD0    = 8'h14;
    localparam logic [7:0] OFF_RCA     = 8'h24;
    localparam logic [7:0] OFF_DSR     = 8'h28;
    localparam logic [7:0] OFF_SCR0    = 8'h2C;
    localparam logic [7:0] OFF_STATUS  = 8'h34;
    localparam logic [7:0] OFF_CONTROL = 8'h38;
    // status bit positions
    localparam int ST_IDLE   = 0;
    localparam int ST_SPI    = 1;
    localparam int ST_PULLUP = 2;
    localparam int ST_WIDE   = 3;
    localparam int ST_RCAOK  = 4;
    localparam int ST_DETECT = 5;
    localparam int ST_OTPLCK = 6;
    localparam int ST_CMD    = 8;
    // command indices
    localparam logic [5:0] CMD_GO_IDLE  = 6'h00;
    localparam logic [5:0] CMD_OP_COND  = 6'h01;
    localparam logic [5:0] CMD_SEND_RCA = 6'h03;
    localparam logic [5:0] CMD_SET_DSR  = 6'h04;
    localparam logic [5:0] CMD_SEND_CSD = 6'h09;
    localparam logic [5:0] CMD_SEND_CID = 6'h0A;
    localparam logic [5:0] CMD_APP      = 6'h37;
    localparam logic [5:0] CMD_READ_VP  = 6'h3A;
    localparam logic [5:0] ACMD_WIDTH   = 6'h06;
    localparam logic [5:0] ACMD_OPCOND  = 6'h29;
    localparam logic [5:0] ACMD_PULLUP  = 6'h2A;
    localparam logic [5:0] ACMD_SCR     = 6'h33;
    // frame geometry
    localparam int CMD_BITS  = 48;
    localparam int RESP_W    = 136;
    localparam logic [7:0] LEN_R1   = 8'h08;
    localparam logic [7:0] LEN_VOLT = 8'h28;
    localparam logic [7:0] LEN_RCA  = 8'h18;
    localparam logic [7:0] LEN_SCR  = 8'h48;
    localparam logic [7:0] LEN_WIDE = 8'h88;
    // response status byte bits, then the four-line width argument code
    localparam int R1_IDLE    = 0;
    localparam int R1_ILLEGAL = 2;
    localparam logic [1:0] WIDTH_FOUR = 2'h2;
endpackage

// >>> tb/mcr_host_model.sv
// host end of the serial link: clock, select and command bits
// assumes the card samples these pins with its own faster clock
`timescale 1ns/10ps
`default_nettype none
module mcr_host_model (
    output logic      link_clk,
    output logic      select_n,
    output logic      serial_in,
    input  wire logic serial_out
);
    initial begin
        link_clk = 1'b0;
        select_n = 1'b1;
        serial_in = 1'b1;
    end
    // link clock only moves inside a frame; crc left zero, card ignores it
    task automatic host_cmd(input logic [5:0] idx, input logic [31:0] arg,
                            input int nr, output logic [135:0] rsp);
        logic [47:0] f;
        f = {2'b01, idx, arg, 7'h00, 1'b1};
        rsp = '0;
        select_n = 1'b0;
        for (int i = 47; i >= 0; i--) begin
            serial_in = f[i];
            #40 link_clk = 1'b1;
            #40 link_clk = 1'b0;
        end
        serial_in = 1'b1;
        for (int i = 0; i < nr; i++) begin
            #40 rsp = {rsp[134:0], serial_out};
            link_clk = 1'b1;
            #40 link_clk = 1'b0;
        end
        #40 select_n = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

// >>> tb/memory_card_register_set_tb_top.sv
// bench: register checks over wishbone, commands through the host model
// assumes the card's default parameters
`timescale 1ns/10ps
`default_nettype none
module memory_card_register_set_tb_top;
    localparam logic [127:0] CARD_SPECIFIC_DATA = 128'h0026_0032_5F59_83C8_BEFB_CFFF_9240_4001;
    logic         clock = 1'b0;
    logic         reset_n = 1'b0;
    logic         cyc = 1'b0;
    logic         we = 1'b0;
    logic [7:0]   adr = 8'h00;
    logic [31:0]  wdat = 32'h0, rdat, dat_o, seed = 32'h5ED0BA3C;
    logic         ack, lclk, sel_n, sin, sout, soe, pu;
    logic [3:0]   dle;
    logic [15:0]  drv;
    logic [135:0] rsp;
    logic [127:0] card_identity;
    int           n_fail = 0;
    int           n_tests = 0;
    always #2.5 clock = ~clock;
    mcr_card_regs dut_u (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .link_clk(lclk), .detect_or_line3(sel_n), .serial_in(sin),
        .serial_out(sout), .serial_out_oe(soe), .pullup_en(pu), .data_line_en(dle),
        .driver_stage(drv));
    mcr_host_model host_u (.link_clk(lclk), .select_n(sel_n), .serial_in(sin),
        .serial_out(sout));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [6:0] crc7(input logic [119:0] d);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 119; i >= 0; i--)
            c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
        return c;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until the rising edge that sees ack high; data taken there
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clock);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clock); while (ack !== 1'b1 && ++t < 50);
        rdat = dat_o;
        if (ack !== 1'b1) n_fail++;
        cyc <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        final_report;
    end
    initial begin
        card_identity = {8'h5A, 16'h4142, 40'h4341_5244_30, 8'h10, 32'h1234_5678, 4'h0, 12'h0A1, 8'h01};
        card_identity[7:1] = crc7(card_identity[127:8]);
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        chk(32'(pu), 32'h1);
        chk(32'(dle), 32'h1);
        chk(32'(drv), 32'h0404);
        wb(1'b1, mcr_pkg::OFF_VOLT, 32'h0);
        rd(mcr_pkg::OFF_VOLT, 32'h00FF_8000);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, mcr_pkg::OFF_CID0 + 8'(4 * i), seed);
            rd(mcr_pkg::OFF_CID0 + 8'(4 * i), card_identity[127 - 32 * i -: 32]);
            rd(mcr_pkg::OFF_CSD0 + 8'(4 * i), CARD_SPECIFIC_DATA[127 - 32 * i -: 32]);
        end
        rd(mcr_pkg::OFF_SCR0, 32'h0225_0000);
        rd(mcr_pkg::OFF_SCR0 + 8'h04, 32'h0);
        wb(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h9240_F001);
        wb(1'b1, 8'h20, 32'h0);
        rd(8'h20, 32'h9240_C001);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wb(1'b1, mcr_pkg::OFF_DSR, seed);
            rd(mcr_pkg::OFF_DSR, {16'h0, seed[15:0]});
            chk(32'(drv), {16'h0, seed[15:0]});
            wb(1'b1, 8'h3C, seed);
            rd(8'h3C, 32'h0);
        end
        host_u.host_cmd(mcr_pkg::CMD_SEND_RCA, 32'h0, 24, rsp);
        chk(32'(rsp[15:0]), 32'h1);
        rd(mcr_pkg::OFF_RCA, 32'h1);
        wb(1'b1, mcr_pkg::OFF_CONTROL, seed);
        host_u.host_cmd(mcr_pkg::CMD_SEND_RCA, 32'h0, 24, rsp);
        chk(32'(rsp[15:0]), {16'h0, seed[15:0]});
        rd(mcr_pkg::OFF_RCA, {16'h0, seed[15:0]});
        host_u.host_cmd(mcr_pkg::CMD_READ_VP, 32'h0, 40, rsp);
        chk(rsp[31:0], 32'h00FF_8000);
        host_u.host_cmd(mcr_pkg::CMD_SEND_CID, 32'h0, 136, rsp);
        for (int i = 0; i < 4; i++)
            chk(rsp[127 - 32 * i -: 32], card_identity[127 - 32 * i -: 32]);
        host_u.host_cmd(6'h3F, 32'h0, 8, rsp);
        chk(32'(rsp[2]), 32'h1);
        host_u.host_cmd(mcr_pkg::CMD_APP, 32'h0, 8, rsp);
        host_u.host_cmd(mcr_pkg::ACMD_WIDTH, 32'(mcr_pkg::WIDTH_FOUR), 8, rsp);
        chk(32'(dle), 32'hF);
        host_u.host_cmd(mcr_pkg::CMD_GO_IDLE, 32'h0, 8, rsp);
        chk(32'(rsp[0]), 32'h1);
        wb(1'b0, mcr_pkg::OFF_STATUS, 32'h0);
        chk(32'(rdat[1:0]), 32'h3);
        chk(32'(sout), 32'h1);
        host_u.host_cmd(mcr_pkg::CMD_APP, 32'h0, 8, rsp);
        host_u.host_cmd(mcr_pkg::ACMD_PULLUP, 32'h0, 8, rsp);
        chk(32'(pu), 32'h0);
        final_report;
    end
endmodule
`default_nettype wire
